// ### hw/llcs_pkg.sv
package llcs_pkg;
  localparam int CLOCK_MHZ       = 100;
  localparam int HOLD_NS         = 2560;
  localparam int HOLD_CYCLES     = (HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RESTART_CYCLES  = 4096;
  localparam int SLOW_TRIP_COUNT = 8;
  localparam int RATE_W          = 8;
  localparam int HALF_BASE       = 300;
  localparam int DEAD_CYCLES     = 20;
  localparam int CNT_W           = 13;
  localparam int SLOW_W          = 4;
  localparam int OSC_W           = 9;
  typedef logic [RATE_W-1:0] llcs_rate_t;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RUN,
    ST_RESTART
  } llcs_state_e;
endpackage : llcs_pkg

// ### hw/llcs_osc_if.sv
`timescale 1ns/1ps
interface llcs_osc_if;
  import llcs_pkg::*;
  logic       run;
  llcs_rate_t rateCode;
  logic       gateLowReq;
  logic       gateHighReq;
  logic       cycleEnd;
  modport osc  (input run, rateCode,
                output gateLowReq, gateHighReq, cycleEnd);
  modport ctrl (output run, rateCode,
                input gateLowReq, gateHighReq, cycleEnd);
endinterface : llcs_osc_if

// ### hw/llcs_osc.sv
`timescale 1ns/1ps
module llcs_osc (
  input wire logic clock,
  input wire logic rst,
  llcs_osc_if.osc  bus
);
  import llcs_pkg::*;

  logic [OSC_W-1:0] cnt;
  logic             phase;
  logic [OSC_W-1:0] halfLimit;
  logic             halfDone;
  logic             pastDead;

  // more feedback current, shorter half period
  // [RL3] rate from current
  assign halfLimit = OSC_W'(HALF_BASE) - OSC_W'(bus.rateCode);
  assign halfDone  = (cnt >= halfLimit - OSC_W'(1));
  assign pastDead  = (cnt >= OSC_W'(DEAD_CYCLES));

  always_ff @(posedge clock) begin
    if (rst || !bus.run) begin
      cnt   <= '0;
      phase <= 1'h0;
    end else if (halfDone) begin
      cnt   <= '0;
      phase <= ~phase;
    end else begin
      cnt   <= cnt + OSC_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus.gateLowReq  <= 1'h0;
      bus.gateHighReq <= 1'h0;
      bus.cycleEnd    <= 1'h0;
    end else begin
      bus.gateLowReq  <= bus.run && !phase && pastDead && !halfDone;
      bus.gateHighReq <= bus.run && phase && pastDead && !halfDone;
      bus.cycleEnd    <= bus.run && phase && halfDone;
    end
  end

  property p_half_rate;
    @(posedge clock) disable iff (rst)
    (bus.run && halfDone && $stable(bus.rateCode))
      |-> (cnt == OSC_W'(HALF_BASE) - OSC_W'(bus.rateCode) - OSC_W'(1));
  endproperty
  a_half_rate: assert property (p_half_rate) // [RL3]
    else $error("half period does not follow rate code");

  property p_no_overlap;
    @(posedge clock) disable iff (rst)
    !(bus.gateLowReq && bus.gateHighReq);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gate requests high");
endmodule : llcs_osc

// ### hw/llcs_sequencer.sv
`timescale 1ns/1ps
// Function
// [RL1] at start-up the feedback pin is pulled up and both gates are held off.
// [RL2] after that hold the pin is released, sensing starts and gates switch.
// [RL3] switching frequency falls as the feedback pin current falls.
// [RL4] a fast overcurrent trip turns both gates off at once.
// [RL5] slow overcurrent on 8 consecutive cycles shuts both gates down.
// [RL6] either overcurrent fault starts auto-restart instead of latching off.
// [RL7] during fault handling the feedback pin is pulled to reference.
// [RL8] after a fault 4096 cycles are counted, then a new soft start begins.
// [RL9] feedback current above the max-frequency current turns gates off.
// [RL10] gates resume once that current falls back below the limit.
// [RL11] the slow overcurrent count clears on any cycle without an excess.
module llcs_sequencer (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 fastOvercurrentTrip,
  input  wire logic                 slowOvercurrentOver,
  input  wire logic                 fbAboveMaxFreq,
  input  wire llcs_pkg::llcs_rate_t fbCurrentCode,
  output logic                      lowSideGateOut,
  output logic                      highSideGateOut,
  output logic                      fbPullUp,
  output logic                      senseEnable,
  output logic                      faultActive
);
  import llcs_pkg::*;

  logic [1:0]        fastSync;
  logic [1:0]        slowSync;
  logic [1:0]        fmaxSync;
  llcs_rate_t        rateMeta;
  llcs_rate_t        rateSync;
  llcs_rate_t        rateLast;
  llcs_rate_t        rateUse;
  logic              rateAgree;
  llcs_state_e       state;
  llcs_state_e       next_state;
  logic [CNT_W-1:0]  waitCnt;
  logic [SLOW_W-1:0] slowCnt;
  logic [SLOW_W-1:0] next_slowCnt;
  logic              slowSeen;
  logic              fastTrip;
  logic              slowNow;
  logic              overLimit;
  logic              slowHit;
  logic              holdDone;
  logic              restartDone;
  logic              gatesOn;
  logic              cycleOver;

  llcs_osc_if oscBus ();

  llcs_osc u_osc (
    .clock (clock),
    .rst   (rst),
    .bus   (oscBus)
  );

  // input synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      fastSync <= '0;
      slowSync <= '0;
      fmaxSync <= '0;
      rateMeta <= '0;
      rateSync <= '0;
    end else begin
      fastSync <= {fastSync[0], fastOvercurrentTrip};
      slowSync <= {slowSync[0], slowOvercurrentOver};
      fmaxSync <= {fmaxSync[0], fbAboveMaxFreq};
      rateMeta <= fbCurrentCode;
      rateSync <= rateMeta;
    end
  end

  // rate word taken only when two samples agree
  assign rateAgree = (rateSync == rateLast);

  always_ff @(posedge clock) begin
    if (rst) begin
      rateLast <= '0;
      rateUse  <= '0;
    end else begin
      rateLast <= rateSync;
      rateUse  <= rateAgree ? rateSync : rateUse;
    end
  end

  assign fastTrip    = fastSync[1];
  assign slowNow     = slowSync[1];
  assign overLimit   = fmaxSync[1];
  assign cycleOver   = slowSeen || slowNow;
  assign holdDone    = (waitCnt == CNT_W'(HOLD_CYCLES - 1));
  assign restartDone = (waitCnt == CNT_W'(RESTART_CYCLES - 1));
  // [RL5] eighth consecutive excess
  assign slowHit     = oscBus.cycleEnd && cycleOver &&
                       (slowCnt == SLOW_W'(SLOW_TRIP_COUNT - 1));
  // [RL9] burst blanking
  assign gatesOn     = (state == ST_RUN) && !overLimit && !fastTrip;

  // [RL3] current code drives rate
  assign oscBus.rateCode = rateUse;
  assign oscBus.run      = (state == ST_RUN);

  // [RL11] clear on clean cycle
  assign next_slowCnt = (state != ST_RUN) ? '0 :
                        !oscBus.cycleEnd  ? slowCnt :
                        cycleOver         ? slowCnt + SLOW_W'(1) : '0;

  always_comb begin
    next_state = state;
    case (state)
      // [RL2] release after hold
      ST_HOLD: begin
        if (holdDone)
          next_state = ST_RUN;
      end
      // [RL6] faults go to restart
      ST_RUN: begin
        if (fastTrip || slowHit)
          next_state = ST_RESTART;
      end
      // [RL8] fresh soft start
      ST_RESTART: begin
        if (restartDone)
          next_state = ST_HOLD;
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state   <= ST_HOLD;
      waitCnt <= '0;
    end else begin
      state   <= next_state;
      waitCnt <= (next_state != state) ? '0 : waitCnt + CNT_W'(1);
    end
  end

  // excess seen this cycle, clear at cycle end wins
  always_ff @(posedge clock) begin
    if (rst) begin
      slowSeen <= 1'h0;
      slowCnt  <= '0;
    end else begin
      slowSeen <= oscBus.cycleEnd ? 1'h0 : (slowSeen || slowNow);
      slowCnt  <= next_slowCnt;
    end
  end

  // [RL1] [RL7] pull-up and gate gating
  always_ff @(posedge clock) begin
    if (rst) begin
      lowSideGateOut  <= 1'h0;
      highSideGateOut <= 1'h0;
      fbPullUp        <= 1'h1;
      senseEnable     <= 1'h0;
      faultActive     <= 1'h0;
    end else begin
      // [RL4] [RL10] immediate off, resume
      lowSideGateOut  <= gatesOn && oscBus.gateLowReq;
      highSideGateOut <= gatesOn && oscBus.gateHighReq;
      fbPullUp        <= (state != ST_RUN);
      senseEnable     <= (state == ST_RUN);
      faultActive     <= (state == ST_RESTART);
    end
  end

  property p_hold_pull;
    @(posedge clock) disable iff (rst)
    (state == ST_HOLD) |=> (fbPullUp && !lowSideGateOut && !highSideGateOut);
  endproperty
  a_hold_pull: assert property (p_hold_pull) // [RL1]
    else $error("hold phase not pulled up with gates off");

  property p_release;
    @(posedge clock) disable iff (rst)
    (state == ST_HOLD && holdDone) |=> ##1 (!fbPullUp && senseEnable);
  endproperty
  a_release: assert property (p_release) // [RL2]
    else $error("feedback pin not released after hold");

  property p_fast_off;
    @(posedge clock) disable iff (rst)
    (state == ST_RUN && fastTrip)
      |=> (state == ST_RESTART) ##0 (!lowSideGateOut && !highSideGateOut);
  endproperty
  a_fast_off: assert property (p_fast_off) // [RL4]
    else $error("fast trip did not turn gates off");

  property p_slow_off;
    @(posedge clock) disable iff (rst)
    (state == ST_RUN && slowHit) |=> (state == ST_RESTART) ##1
      (!lowSideGateOut && !highSideGateOut && faultActive);
  endproperty
  a_slow_off: assert property (p_slow_off) // [RL5]
    else $error("eighth slow excess did not shut down");

  property p_fault_restart;
    @(posedge clock) disable iff (rst)
    $rose(state == ST_RESTART) |-> (waitCnt == '0);
  endproperty
  a_fault_restart: assert property (p_fault_restart) // [RL6]
    else $error("restart wait not started from zero");

  property p_fault_pull;
    @(posedge clock) disable iff (rst)
    (state == ST_RESTART) |=> fbPullUp;
  endproperty
  a_fault_pull: assert property (p_fault_pull) // [RL7]
    else $error("feedback pin not pulled up during fault");

  property p_restart_wait;
    @(posedge clock) disable iff (rst)
    (state == ST_RESTART && restartDone) |=> (state == ST_HOLD);
  endproperty
  a_restart_wait: assert property (p_restart_wait) // [RL8]
    else $error("restart wait did not end in soft start");

  property p_burst_off;
    @(posedge clock) disable iff (rst)
    (state == ST_RUN && overLimit)
      |=> (!lowSideGateOut && !highSideGateOut);
  endproperty
  a_burst_off: assert property (p_burst_off) // [RL9]
    else $error("gates on above max frequency current");

  property p_burst_resume;
    @(posedge clock) disable iff (rst)
    (state == ST_RUN && !overLimit && !fastTrip && oscBus.gateLowReq)
      |=> lowSideGateOut;
  endproperty
  a_burst_resume: assert property (p_burst_resume) // [RL10]
    else $error("gates did not resume below limit");

  property p_slow_clear;
    @(posedge clock) disable iff (rst)
    (state == ST_RUN && oscBus.cycleEnd && !cycleOver) |=> (slowCnt == '0);
  endproperty
  a_slow_clear: assert property (p_slow_clear) // [RL11]
    else $error("slow count not cleared on clean cycle");
endmodule : llcs_sequencer

// ### bench/llcs_stage_model.sv
`timescale 1ns/1ps
module llcs_stage_model (
  input  wire logic                 clock,
  input  wire logic                 fbPullUp,
  input  wire logic                 fastCmd,
  input  wire logic                 slowCmd,
  input  wire logic                 burstCmd,
  output logic                      fastOvercurrentTrip,
  output logic                      slowOvercurrentOver,
  output logic                      fbAboveMaxFreq,
  output llcs_pkg::llcs_rate_t      fbCurrentCode
);
  import llcs_pkg::*;
  localparam llcs_rate_t START_CODE = 8'hC8;
  localparam llcs_rate_t MIN_CODE   = 8'h64;
  logic [5:0] tick;
  initial begin
    tick = 6'h00;
    fastOvercurrentTrip = 1'h0;
    slowOvercurrentOver = 1'h0;
    fbAboveMaxFreq = 1'h0;
    fbCurrentCode = START_CODE;
  end
  // comparators follow the commanded faults
  always @(negedge clock) begin
    fastOvercurrentTrip <= fastCmd;
    slowOvercurrentOver <= slowCmd;
    fbAboveMaxFreq <= burstCmd;
    tick <= tick + 6'h01;
    // charging soft-start cap lowers the current
    if (fbPullUp)
      fbCurrentCode <= START_CODE;
    else if (tick == 6'h3F && fbCurrentCode > MIN_CODE)
      fbCurrentCode <= fbCurrentCode - 8'h01;
  end
endmodule : llcs_stage_model

// ### bench/test_llcs_sequencer.sv
`timescale 1ns/1ps
module test_llcs_sequencer;
  import llcs_pkg::*;
  logic       clock = 1'h0;
  logic       rst = 1'h1;
  logic       fastCmd = 1'h0;
  logic       slowCmd = 1'h0;
  logic       burstCmd = 1'h0;
  logic       fastOvercurrentTrip;
  logic       slowOvercurrentOver;
  logic       fbAboveMaxFreq;
  llcs_rate_t fbCurrentCode;
  logic       lowSideGateOut;
  logic       highSideGateOut;
  logic       fbPullUp;
  logic       senseEnable;
  logic       faultActive;
  int         fail_count = 0;
  int         checks = 0;
  always #5 clock = ~clock;
  llcs_sequencer dut (.clock(clock), .rst(rst),
    .fastOvercurrentTrip(fastOvercurrentTrip),
    .slowOvercurrentOver(slowOvercurrentOver),
    .fbAboveMaxFreq(fbAboveMaxFreq), .fbCurrentCode(fbCurrentCode),
    .lowSideGateOut(lowSideGateOut), .highSideGateOut(highSideGateOut),
    .fbPullUp(fbPullUp), .senseEnable(senseEnable),
    .faultActive(faultActive));
  llcs_stage_model stage (.clock(clock), .fbPullUp(fbPullUp),
    .fastCmd(fastCmd), .slowCmd(slowCmd), .burstCmd(burstCmd),
    .fastOvercurrentTrip(fastOvercurrentTrip),
    .slowOvercurrentOver(slowOvercurrentOver),
    .fbAboveMaxFreq(fbAboveMaxFreq), .fbCurrentCode(fbCurrentCode));
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", what, exp, got);
    end
  endtask : chk
  task automatic chkn(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] %s exp %0d got %0d", what, exp, got);
    end
  endtask : chkn
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // cycles until the low gate next rises
  task automatic wait_rise(output int n);
    logic prev;
    n = 0;
    prev = lowSideGateOut;
    while (n < 2000 && !(lowSideGateOut === 1'h1 && prev !== 1'h1)) begin
      prev = lowSideGateOut;
      cyc(1);
      n++;
    end
  endtask : wait_rise
  task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic t_start;
    int   n;
    logic hi;
    logic both;
    cyc(10);
    chk("pullUp", 1'h1, fbPullUp);
    chk("gates", 1'h0, lowSideGateOut | highSideGateOut);
    chk("sense", 1'h0, senseEnable);
    cyc(260);
    chk("pullUp", 1'h0, fbPullUp);
    chk("sense", 1'h1, senseEnable);
    wait_rise(n);
    chk("switching", 1'h1, n < 700);
    hi = 1'h0;
    both = 1'h0;
    repeat (250) begin
      hi = hi | highSideGateOut;
      both = both | (lowSideGateOut & highSideGateOut);
      cyc(1);
    end
    chk("highSwitching", 1'h1, hi);
    chk("gateOverlap", 1'h0, both);
  endtask : t_start
  task automatic t_softstart;
    int n, p0, p1;
    wait_rise(p0);
    cyc(7000);
    wait_rise(n);
    wait_rise(p1);
    chk("periodGrows", 1'h1, p1 > p0);
  endtask : t_softstart
  task automatic t_burst;
    int n;
    logic on;
    burstCmd <= 1'h1;
    cyc(8);
    on = 1'h0;
    repeat (500) begin
      on = on | lowSideGateOut | highSideGateOut;
      cyc(1);
    end
    chk("burstOff", 1'h0, on);
    burstCmd <= 1'h0;
    wait_rise(n);
    chk("burstResume", 1'h1, n < 900);
  endtask : t_burst
  task automatic t_fast;
    int n;
    int hiCnt;
    wait_rise(n);
    fastCmd <= 1'h1;
    hiCnt = 0;
    for (int i = 1; i <= 4200; i++) begin
      cyc(1);
      if (faultActive === 1'h1)
        hiCnt++;
      if (i == 4)
        chk("gates", 1'h0, lowSideGateOut | highSideGateOut);
      if (i == 5) begin
        chk("fault", 1'h1, faultActive);
        chk("pullUp", 1'h1, fbPullUp);
        fastCmd <= 1'h0;
      end
      if (i == 4080)
        chk("waiting", 1'h1, faultActive);
    end
    chkn("waitLen", RESTART_CYCLES, hiCnt);
    chk("waitDone", 1'h0, faultActive);
    chk("holdAgain", 1'h1, fbPullUp);
    cyc(200);
    chk("released", 1'h0, fbPullUp);
    wait_rise(n);
    chk("restarted", 1'h1, n < 700);
  endtask : t_fast
  task automatic t_slow;
    int   n;
    int   rises;
    logic prev;
    slowCmd <= 1'h1;
    repeat (6) wait_rise(n);
    slowCmd <= 1'h0;
    chk("sixCycles", 1'h0, faultActive);
    repeat (2) wait_rise(n);
    slowCmd <= 1'h1;
    n = 0;
    rises = 0;
    prev = lowSideGateOut;
    while (faultActive !== 1'h1 && n < 4000) begin
      cyc(1);
      n++;
      if (lowSideGateOut === 1'h1 && prev !== 1'h1)
        rises++;
      prev = lowSideGateOut;
    end
    chk("countCleared", 1'h1, rises >= 4);
    chkn("slowRises", SLOW_TRIP_COUNT - 1, rises);
    chk("slowTrip", 1'h1, faultActive);
    chk("gates", 1'h0, lowSideGateOut | highSideGateOut);
    slowCmd <= 1'h0;
  endtask : t_slow
  initial begin
    #400000;
    fail_count++;
    final_report;
  end
  initial begin
    cyc(2);
    rst <= 1'h0;
    t_start;
    t_softstart;
    t_burst;
    t_fast;
    t_slow;
    final_report;
  end
endmodule : test_llcs_sequencer
